// ===== common/nvsq_pkg.sv
// Package of constants for the shadow-SRAM host sequencer
package nvsq_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // ************************************************
   // Device timing (nanoseconds / microseconds / milliseconds)
   // ************************************************
   localparam int unsigned ADDR_ACCESS_TIME_NS = 45;
   localparam int unsigned CS_ACCESS_TIME_NS = 45;
   localparam int unsigned OE_ACCESS_TIME_NS = 20;
   localparam int unsigned DATA_SETUP_WR_END_NS = 15;
   localparam int unsigned WRITE_PULSE_NS = 30;
   localparam int unsigned WRITE_TO_OUTPUT_OFF_DELAY_NS = 15;
   localparam int unsigned LOAD_DURATION_US = 20;
   localparam int unsigned SAVE_DURATION_MS = 10;
   localparam int unsigned POWERUP_LOAD_DURATION_US = 550;
   // Least times round up, at least one cycle
   function automatic int unsigned ns_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
      return (c == 0) ? 1 : c;
   endfunction
   localparam int unsigned READ_CYC = ns_cyc(CS_ACCESS_TIME_NS > ADDR_ACCESS_TIME_NS ?
      CS_ACCESS_TIME_NS : ADDR_ACCESS_TIME_NS) + 1;
   localparam int unsigned WRITE_CYC = ns_cyc(WRITE_PULSE_NS > DATA_SETUP_WR_END_NS +
      WRITE_TO_OUTPUT_OFF_DELAY_NS ? WRITE_PULSE_NS : DATA_SETUP_WR_END_NS +
      WRITE_TO_OUTPUT_OFF_DELAY_NS);
   localparam int unsigned LOAD_CYC = LOAD_DURATION_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SAVE_CYC = SAVE_DURATION_MS * (CLK_HZ / 1000);
   localparam int unsigned PWRUP_CYC = POWERUP_LOAD_DURATION_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W = 20;
   // ************************************************
   // Sequence addresses
   // ************************************************
   localparam logic [13:0] SEQ_A0 = 14'h0E38;
   localparam logic [13:0] SEQ_A1 = 14'h31C7;
   localparam logic [13:0] SEQ_A2 = 14'h03E0;
   localparam logic [13:0] SEQ_A3 = 14'h3C1F;
   localparam logic [13:0] SEQ_A4 = 14'h303F;
   localparam logic [13:0] SEQ_SAVE = 14'h0FC0;
   localparam logic [13:0] SEQ_LOAD = 14'h0C63;
   function automatic logic [13:0] seq_addr(input logic [2:0] i, input logic load);
      case (i)
         3'h0: return SEQ_A0;
         3'h1: return SEQ_A1;
         3'h2: return SEQ_A2;
         3'h3: return SEQ_A3;
         3'h4: return SEQ_A4;
         default: return load ? SEQ_LOAD : SEQ_SAVE;
      endcase
   endfunction
   // ************************************************
   // Host command codes
   // ************************************************
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_SAVE = 2'h2;
   localparam logic [1:0] CMD_LOAD = 2'h3;
   typedef enum logic [2:0] {
      NVSQ_IDLE = 3'b000,
      NVSQ_ACC = 3'b001,
      NVSQ_GAP = 3'b011,
      NVSQ_WAIT = 3'b010,
      NVSQ_PWR = 3'b110
   } nvsq_state_e;
endpackage

// ===== logic/nvsq_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module nvsq_sync import nvsq_pkg::*; #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== logic/nvsq_host.sv
// Host sequencer driving the shadow-SRAM pins: access, save and load
`timescale 1ns/1ps
`default_nettype none
module nvsq_host import nvsq_pkg::*; (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // Command port
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD_OP,
   input wire logic [14:0] CMD_ADDR,
   input wire logic [7:0] CMD_WDATA,
   output logic CMD_READY,
   output logic RSP_VALID,
   output logic [7:0] RSP_RDATA,
   // Supply monitor (asynchronous, high while supply above trip)
   input wire logic SUPPLY_OK,
   // Memory pins
   output logic MEM_CS_N,
   output logic MEM_WE_N,
   output logic MEM_OE_N,
   output logic [14:0] MEM_ADDR,
   input wire logic [7:0] MEM_DQ_I,
   output logic [7:0] MEM_DQ_O,
   output logic MEM_DQ_OE
);
   typedef struct packed {
      nvsq_state_e st;
      logic [1:0] op;
      logic [2:0] step;
      logic [CNT_W-1:0] cnt;
      logic ready;
      logic rsp;
      logic [7:0] rdata;
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic [14:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic was_low;
   } nvsq_s;
   nvsq_s r, next_r;
   logic supply_ok;
   nvsq_sync #(.W(1)) u_sync (
      .clk(SYS_CLK),
      .resetn(RESETN),
      .d(SUPPLY_OK),
      .q(supply_ok)
   );
   // Reset asserted, or supply low seen in idle: wait for power-up load before access
   always_comb begin
      next_r = r;
      next_r.rsp = 1'b0;
      next_r.was_low = r.was_low | ~supply_ok;
      case (r.st)
         NVSQ_IDLE: begin
            next_r.ready = 1'b0;
            if (!supply_ok) begin
               next_r.st = NVSQ_PWR;
               next_r.cnt = '0;
            end else if (CMD_VALID && r.ready) begin
               next_r.op = CMD_OP;
               next_r.step = '0;
               next_r.cnt = '0;
               next_r.st = NVSQ_ACC;
               next_r.cs_n = 1'b0;
               if (CMD_OP == CMD_WRITE) begin
                  next_r.addr = CMD_ADDR;
                  next_r.oe_n = 1'b1;
                  next_r.we_n = 1'b0;
                  next_r.dq = CMD_WDATA;
                  next_r.dq_oe = 1'b1;
               end else if (CMD_OP == CMD_READ) begin
                  next_r.addr = CMD_ADDR;
                  next_r.oe_n = 1'b0;
                  next_r.we_n = 1'b1;
               end else begin
                  // Sequence reads: strobe high, outputs off, top bit zero
                  next_r.addr = {1'b0, seq_addr(3'h0, CMD_OP == CMD_LOAD)};
                  next_r.oe_n = 1'b1;
                  next_r.we_n = 1'b1;
               end
            end else begin
               next_r.ready = 1'b1;
            end
         end
         NVSQ_ACC: begin
            // One select fall per access, held for the full cycle
            next_r.cnt = r.cnt + 1'b1;
            if (r.op == CMD_WRITE) begin
               if (r.cnt == CNT_W'(WRITE_CYC - 1)) begin
                  next_r.we_n = 1'b1;
                  next_r.cs_n = 1'b1;
                  next_r.st = NVSQ_GAP;
               end
            end else if (r.cnt == CNT_W'(READ_CYC - 1)) begin
               next_r.rdata = MEM_DQ_I;
               next_r.cs_n = 1'b1;
               next_r.oe_n = 1'b1;
               next_r.st = NVSQ_GAP;
            end
         end
         NVSQ_GAP: begin
            // Address and data held one cycle past the strobe rise
            next_r.dq_oe = 1'b0;
            next_r.cnt = '0;
            if (r.op == CMD_READ || r.op == CMD_WRITE) begin
               next_r.rsp = 1'b1;
               next_r.st = NVSQ_IDLE;
            end else if (r.step == 3'h5) begin
               next_r.st = NVSQ_WAIT;
            end else if (!supply_ok && r.op == CMD_SAVE) begin
               // Device ignores saves below trip; abandon the sequence
               next_r.rsp = 1'b1;
               next_r.st = NVSQ_IDLE;
            end else begin
               // Next sequence step, no intervening access
               next_r.step = r.step + 1'b1;
               next_r.addr = {1'b0, seq_addr(r.step + 1'b1, r.op == CMD_LOAD)};
               next_r.cs_n = 1'b0;
               next_r.st = NVSQ_ACC;
            end
         end
         NVSQ_WAIT: begin
            // Device inaccessible while erase/program or clear/copy runs
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == CNT_W'((r.op == CMD_LOAD ? LOAD_CYC : SAVE_CYC) - 1)) begin
               next_r.rsp = 1'b1;
               next_r.st = NVSQ_IDLE;
            end
         end
         default: begin
            // Power-up load: bus parked, strobe high so no write state
            next_r.cs_n = 1'b1;
            next_r.we_n = 1'b1;
            next_r.oe_n = 1'b1;
            next_r.dq_oe = 1'b0;
            next_r.ready = 1'b0;
            if (!supply_ok) begin
               next_r.cnt = '0;
            end else begin
               next_r.cnt = r.cnt + 1'b1;
               if (r.cnt == CNT_W'(PWRUP_CYC - 1)) begin
                  next_r.st = NVSQ_IDLE;
               end
            end
         end
      endcase
   end
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         r <= '{st: NVSQ_PWR, op: CMD_READ, step: 3'h0, cnt: '0, ready: 1'b0, rsp: 1'b0,
                rdata: 8'h00, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 15'h0000,
                dq: 8'h00, dq_oe: 1'b0, was_low: 1'b0};
      end else begin
         r <= next_r;
      end
   end
   assign CMD_READY = r.ready;
   assign RSP_VALID = r.rsp;
   assign RSP_RDATA = r.rdata;
   assign MEM_CS_N = r.cs_n;
   assign MEM_WE_N = r.we_n;
   assign MEM_OE_N = r.oe_n;
   assign MEM_ADDR = r.addr;
   assign MEM_DQ_O = r.dq;
   assign MEM_DQ_OE = r.dq_oe;
endmodule
`default_nettype wire

// ===== tb/nvsq_chk.sv
// Pin and handshake checker for the host sequencer
`timescale 1ns/1ps
`default_nettype none
module nvsq_chk import nvsq_pkg::*; (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // Command side
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD_OP,
   input wire logic CMD_READY,
   input wire logic RSP_VALID,
   input wire logic SUPPLY_OK,
   // Memory pins
   input wire logic MEM_CS_N,
   input wire logic MEM_WE_N,
   input wire logic MEM_OE_N,
   input wire logic [14:0] MEM_ADDR,
   input wire logic MEM_DQ_OE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   rd_answer_a: assert property (CMD_VALID && CMD_READY && CMD_OP == CMD_READ |-> ##4 RSP_VALID)
      else $error("read answer late");
   wr_answer_a: assert property (CMD_VALID && CMD_READY && CMD_OP == CMD_WRITE |-> ##3 RSP_VALID)
      else $error("write answer late");
   wr_pulse_a: assert property ($fell(MEM_WE_N) |=> MEM_WE_N)
      else $error("write pulse length");
   wr_oe_high_a: assert property (!MEM_WE_N |-> MEM_OE_N && MEM_DQ_OE)
      else $error("write with output enabled");
   wr_addr_hold_a: assert property (!MEM_CS_N && !MEM_WE_N |=> $stable(MEM_ADDR) || MEM_WE_N)
      else $error("address moved in write");
   rd_pulse_a: assert property ($fell(MEM_CS_N) && MEM_WE_N |-> !MEM_CS_N [*2] ##1 MEM_CS_N)
      else $error("read select length");
   cs_addr_hold_a: assert property (!MEM_CS_N && !$fell(MEM_CS_N) |-> $stable(MEM_ADDR))
      else $error("address moved under select");
   rd_we_high_a: assert property (!MEM_CS_N && !MEM_OE_N |-> MEM_WE_N)
      else $error("read with write strobe");
   take_drop_a: assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
      else $error("ready held after take");
   low_no_wr_a: assert property (!SUPPLY_OK [*8] |-> MEM_WE_N)
      else $error("write at low supply");
   cover property (CMD_VALID && CMD_READY && CMD_OP == CMD_LOAD);
   cover property ($fell(MEM_WE_N));
   cover property ($fell(SUPPLY_OK));
endmodule
bind nvsq_host nvsq_chk i_chk (.*);
`default_nettype wire

// ===== tb/nvsq_mem_model.sv
// Behavioural shadow-SRAM device on the host pins
`timescale 1ns/1ps
`default_nettype none
module nvsq_mem_model #(parameter int DLY = 40) (
   // Memory pins
   input wire logic MEM_CS_N,
   input wire logic MEM_WE_N,
   input wire logic MEM_OE_N,
   input wire logic [14:0] MEM_ADDR,
   input wire logic [7:0] MEM_DQ_O,
   input wire logic MEM_DQ_OE,
   output logic [7:0] MEM_DQ_I,
   // Supply
   input wire logic SUPPLY_OK
);
   logic [7:0] sram[32768], nv[32768], last;
   logic [13:0] tab[6] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F, 14'h0FC0};
   int step = 0;
   bit dirty = 0;
   // Unknown-to-low at start-up is not a real write end
   bit armed = 0;
   wire logic rd = !MEM_CS_N && !MEM_OE_N && MEM_WE_N;
   wire logic wr = !MEM_CS_N && !MEM_WE_N;
   initial begin
      for (int i = 0; i < 32768; i++) begin
         nv[i] = 8'(i ^ 'hA5);
         sram[i] = nv[i];
      end
      last = 8'h00;
   end
   // Released bus shows the inverted last byte, never a stale copy
   always @(negedge rd) last = sram[MEM_ADDR];
   assign #DLY MEM_DQ_I = rd ? sram[MEM_ADDR] : ~last;
   always @(posedge wr) armed = 1;
   always @(negedge wr) if (SUPPLY_OK && armed) begin
      sram[MEM_ADDR] = MEM_DQ_OE ? MEM_DQ_O : ~last;
      dirty = 1;
      step = 0;
   end
   always @(negedge MEM_CS_N) if (MEM_WE_N) begin
      if (MEM_ADDR[13:0] == tab[step]) step++;
      else if (step == 5 && MEM_ADDR[13:0] == 14'h0C63) step = 7;
      else step = (MEM_ADDR[13:0] == tab[0]);
      if (step == 6 && SUPPLY_OK) nv = sram;
      if (step == 7) sram = nv;
      if (step > 5) begin
         step = 0;
         dirty = 0;
      end
   end
   always @(negedge SUPPLY_OK) begin
      if (dirty) nv = sram;
      dirty = 0;
   end
   always @(posedge SUPPLY_OK) sram = nv;
endmodule
`default_nettype wire

// ===== tb/nv_shadow_sram_sequencer_test.sv
// Self-checking bench for the shadow-SRAM host sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %0t read data", $time); end end
module nv_shadow_sram_sequencer_test;
   import nvsq_pkg::*;
   logic SYS_CLK = 0, RESETN = 0, CMD_VALID = 0, SUPPLY_OK = 1;
   logic [1:0] CMD_OP = 0;
   logic [14:0] CMD_ADDR = 0;
   logic [7:0] CMD_WDATA = 0;
   wire logic CMD_READY, RSP_VALID, MEM_CS_N, MEM_WE_N, MEM_OE_N, MEM_DQ_OE;
   wire logic [7:0] RSP_RDATA, MEM_DQ_I, MEM_DQ_O;
   wire logic [14:0] MEM_ADDR;
   int miscompares = 0, n_tests = 0;
   int m_sram[int], m_nv[int];
   bit dirty = 0;
   always #50 SYS_CLK = ~SYS_CLK;
   nvsq_host i_dut (.*);
   nvsq_mem_model i_mem (.*);
   function automatic logic [7:0] rd(int a);
      return m_sram.exists(a) ? 8'(m_sram[a]) : 8'(a ^ 'hA5);
   endfunction
   // Entered and left 10 ns after an edge
   task automatic cmd(logic [1:0] op, logic [14:0] a, logic [7:0] d);
      int k;
      k = 0;
      CMD_VALID = 1;
      CMD_OP = op;
      CMD_ADDR = a;
      CMD_WDATA = d;
      while (CMD_READY !== 1'b1 && k < 20000) begin @(posedge SYS_CLK); #10; k++; end
      @(posedge SYS_CLK); #10;
      CMD_VALID = 0;
      while (RSP_VALID !== 1'b1 && k < 20000) begin @(posedge SYS_CLK); #10; k++; end
      if (k >= 20000) begin miscompares++; $display("mismatch %0t command hung", $time); end
      if (op == CMD_WRITE) begin m_sram[a] = d; dirty = 1; end
      if (op == CMD_LOAD) begin m_sram = m_nv; dirty = 0; end
   endtask
   task automatic power_cycle();
      if (dirty) m_nv = m_sram;
      m_sram = m_nv;
      dirty = 0;
      SUPPLY_OK = 0;
      repeat (20) @(posedge SYS_CLK);
      #10 SUPPLY_OK = 1;
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #(30000 * 100);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      logic [14:0] a[8];
      void'($urandom(32'h5005));
      repeat (4) @(posedge SYS_CLK);
      #10 RESETN = 1;
      foreach (a[i]) begin a[i] = 15'($urandom); cmd(CMD_WRITE, a[i], 8'($urandom)); end
      foreach (a[i]) begin cmd(CMD_READ, a[i], 0); `CHK(RSP_RDATA, rd(a[i])) end
      $display("test write read done");
      cmd(CMD_LOAD, 0, 0);
      cmd(CMD_READ, a[0], 0); `CHK(RSP_RDATA, rd(a[0]))
      $display("test load done");
      power_cycle();
      cmd(CMD_READ, a[1], 0); `CHK(RSP_RDATA, rd(a[1]))
      cmd(CMD_WRITE, a[2], 8'h5A);
      power_cycle();
      cmd(CMD_READ, a[2], 0); `CHK(RSP_RDATA, rd(a[2]))
      $display("test power cycle done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
